// >>> dcd_defines.vh
// Constants for the signal-processor core datapath
`ifndef DCD_DEFINES_VH
`define DCD_DEFINES_VH
`define DCD_ACC_RST 32'h0000_0000
`define DCD_WORD_RST 16'h0000
`define DCD_PAGE_RST 9'h000
`define DCD_INT_RST 7'h00
`define DCD_ST1_RST 16'h0000
`define DCD_ST1_C_BIT 9
`define DCD_ST1_CNF_BIT 12
`define DCD_B1_BASE 16'h0300
`define DCD_B1_TOP 16'h03ff
`define DCD_B2_BASE 16'h0060
`define DCD_B2_TOP 16'h007f
`define DCD_B0_DATA_BASE 16'h0200
`define DCD_B0_DATA_TOP 16'h02ff
`define DCD_B0_PROG_BASE 16'hff00
`define DCD_B0_PROG_TOP 16'hffff
`define DCD_PROD_SH1 2'h1
`define DCD_PROD_SH4 2'h2
`define DCD_PROD_SHR6 2'h3
`define DCD_ALU_PASS 3'h0
`define DCD_ALU_ADD 3'h1
`define DCD_ALU_SUB 3'h2
`define DCD_ALU_ADDC 3'h3
`define DCD_ALU_AND 3'h4
`define DCD_ALU_OR 3'h5
`define DCD_ALU_XOR 3'h6
`define DCD_ALU_SUBB 3'h7
`define DCD_SH_NONE 2'h0
`define DCD_SH_SFL 2'h1
`define DCD_SH_ROL 2'h2
`define DCD_SH_ROR 2'h3
`define DCD_AR_NONE 2'h0
`define DCD_AR_INC 2'h1
`define DCD_AR_DEC 2'h2
`define DCD_AR_IDX 2'h3
`define DCD_PC_SEQ 2'h0
`define DCD_PC_JMP 2'h1
`define DCD_PC_CALL 2'h2
`define DCD_PC_RET 2'h3
`define DCD_STACK_DEPTH 8
`define DCD_INT_LINES 7
`endif

// >>> dcd_core_datapath.v
// Datapath and program-address logic of the fixed-point core
`timescale 1ns/1ps
`include "dcd_defines.vh"
// Notes on behaviour
// [RULE1] 32-bit accumulator with shift and rotate
// [RULE2] Unsigned 16-bit unit computes indirect addresses
// [RULE3] Eight pointers; zero is step and compare
// [RULE4] Carry feeds extended ops, shifts, status one
// [RULE5] Main unit completes 32-bit op per cycle
// [RULE6] Map select moves block zero data/program
// [RULE7] Blocks one, two fixed in data space
// [RULE8] Blocks zero/one 256 words, two 32
// [RULE9] Direct address is page plus seven bits
// [RULE10] Global space size register reserved
// [RULE11] Mask enables each of seven lines
// [RULE12] Seven-bit pending flags latch interrupts
// [RULE13] Thirty-two trap vectors, hardware or software
// [RULE14] Input shifter shifts 0-16 left, no cycle
// [RULE15] Single-cycle signed or unsigned 16x16 multiply
// [RULE16] Micro return store keeps next fetch address
// [RULE17] Output shifter 0-7 left, high/low half
// [RULE18] Next fetch address drives bus next cycle
// [RULE19] Current fetch address holds through waits
// [RULE20] Counter increments next fetch address
// [RULE21] Controller holds status, evaluates conditions
// [RULE22] Pointer select 0-7 picks auxiliary register
// [RULE23] Product shifter 0/1/4 left or 6 right
// [RULE24] Return stack 16 wide, 8 deep
// [RULE25] Four-deep pipeline, single-cycle instructions
// [RULE26] Pointer updates wrap, no overflow flag
module dcd_core_datapath (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Pipeline control
  input wire STEP,
  input wire [15:0] INSTR,
  // Arithmetic control
  input wire [15:0] DATA_IN,
  input wire [4:0] IN_SHIFT,
  input wire IN_SEL_PROD,
  input wire [2:0] ALU_OP,
  input wire ACC_LOAD,
  input wire [1:0] ACC_SHIFT,
  input wire [15:0] MUL_OPND,
  input wire MUL_SIGNED,
  input wire MUL_LOAD,
  input wire [1:0] PROD_MODE,
  input wire [2:0] OUT_SHIFT,
  input wire OUT_HIGH,
  // Addressing control
  input wire DIRECT_MODE,
  input wire [1:0] AR_UPDATE,
  input wire AR_LOAD,
  input wire [2:0] AR_LOAD_SEL,
  input wire [15:0] AR_LOAD_VAL,
  input wire PTR_LOAD,
  input wire [2:0] PTR_VAL,
  input wire LOAD_PAGE,
  input wire LOAD_STATUS,
  input wire [15:0] STATUS_VAL,
  input wire [1:0] COND_SEL,
  // Program sequencing
  input wire [1:0] PC_MODE,
  input wire [15:0] PC_TARGET,
  input wire BLOCK_XFER,
  input wire BUS_WAIT,
  // Interrupts
  input wire [6:0] INT_REQ,
  input wire MASK_LOAD,
  input wire [6:0] MASK_VAL,
  input wire [6:0] FLAG_CLR,
  input wire TRAP_SW,
  input wire [4:0] TRAP_NUM,
  // Outputs
  output reg [15:0] PROGRAM_ADDR_BUS,
  output reg [15:0] DATA_ADDR,
  output reg DATA_IN_BLOCK_ZERO,
  output reg DATA_IN_BLOCK_ONE,
  output reg DATA_IN_BLOCK_TWO,
  output reg PROG_IN_BLOCK_ZERO,
  output reg [15:0] WRITE_DATA_BUS,
  output reg [31:0] ACCUM,
  output reg CARRY,
  output reg [15:0] STATUS_WORD_ONE,
  output reg [8:0] PAGE_PTR,
  output reg [2:0] AUX_SEL,
  output reg AUX_MATCH,
  output reg COND_TRUE,
  output reg [6:0] INT_MASK,
  output reg [6:0] INT_FLAG,
  output reg INT_TAKE,
  output reg [4:0] TRAP_VECTOR,
  output reg [15:0] GLOBAL_SPACE_SIZE,
  output reg [3:0] PIPE_VALID
);

////////////////////////////////////////////////////////////////////////
// Storage
reg [31:0] accum_reg;
reg [31:0] prod_reg;
reg [15:0] aux_r [0:7];
reg [15:0] stack_r [0:`DCD_STACK_DEPTH-1];
reg [2:0] sp_r;
reg [15:0] next_fetch_addr;
reg [15:0] current_fetch_addr;
reg [15:0] micro_return_store;
reg [15:0] pipe_r [0:3];
reg [6:0] int_pend_r;
reg in_xfer_r;
reg [6:0] int_sync1_r;
reg [6:0] int_sync2_r;
reg [6:0] int_prev_r;
wire [15:0] aux_reg_zero = aux_r[0];
wire [15:0] sel_aux = aux_r[AUX_SEL];

////////////////////////////////////////////////////////////////////////
// Shifters, multiplier, main arithmetic unit
wire [31:0] input_shifter = {16'h0000, DATA_IN} << IN_SHIFT; // [RULE14]
wire signed [32:0] mul_a = MUL_SIGNED ? {{17{MUL_OPND[15]}}, MUL_OPND} : {17'h00000, MUL_OPND};
wire signed [32:0] mul_b = MUL_SIGNED ? {{17{DATA_IN[15]}}, DATA_IN} : {17'h00000, DATA_IN};
wire signed [32:0] mul_full = mul_a * mul_b;
wire [31:0] multiplier = mul_full[31:0]; // [RULE15]
reg [31:0] product_shifter;
always @*
begin
  case (PROD_MODE) // [RULE23]
    `DCD_PROD_SH1: product_shifter = {prod_reg[30:0], 1'b0};
    `DCD_PROD_SH4: product_shifter = {prod_reg[27:0], 4'h0};
    `DCD_PROD_SHR6: product_shifter = {{6{prod_reg[31]}}, prod_reg[31:6]};
    default: product_shifter = prod_reg;
  endcase
end
wire [31:0] alu_b = IN_SEL_PROD ? product_shifter : input_shifter;
reg [32:0] main_arith_unit;
always @*
begin
  case (ALU_OP) // [RULE5]
    `DCD_ALU_ADD: main_arith_unit = {1'b0, accum_reg} + {1'b0, alu_b};
    `DCD_ALU_SUB: main_arith_unit = {1'b0, accum_reg} + {1'b0, ~alu_b} + 33'h000000001;
    `DCD_ALU_ADDC: main_arith_unit = {1'b0, accum_reg} + {1'b0, alu_b} + {32'h00000000, CARRY}; // [RULE4]
    `DCD_ALU_SUBB: main_arith_unit = {1'b0, accum_reg} + {1'b0, ~alu_b} + {32'h00000000, CARRY};
    `DCD_ALU_AND: main_arith_unit = {CARRY, accum_reg & alu_b};
    `DCD_ALU_OR: main_arith_unit = {CARRY, accum_reg | alu_b};
    `DCD_ALU_XOR: main_arith_unit = {CARRY, accum_reg ^ alu_b};
    default: main_arith_unit = {CARRY, alu_b};
  endcase
end
reg [32:0] acc_nxt;
always @*
begin
  case (ACC_SHIFT) // [RULE1]
    `DCD_SH_SFL: acc_nxt = {accum_reg, 1'b0};
    `DCD_SH_ROL: acc_nxt = {accum_reg, CARRY}; // [RULE4]
    `DCD_SH_ROR: acc_nxt = {accum_reg[0], CARRY, accum_reg[31:1]};
    default: acc_nxt = main_arith_unit;
  endcase
end
wire [31:0] output_shifter = accum_reg << OUT_SHIFT; // [RULE17]

////////////////////////////////////////////////////////////////////////
// Addressing
reg [15:0] aux_addr_arith;
always @*
begin
  case (AR_UPDATE) // [RULE2] [RULE26]
    `DCD_AR_INC: aux_addr_arith = sel_aux + 16'h0001;
    `DCD_AR_DEC: aux_addr_arith = sel_aux - 16'h0001;
    `DCD_AR_IDX: aux_addr_arith = sel_aux + aux_reg_zero; // [RULE3]
    default: aux_addr_arith = sel_aux;
  endcase
end
wire [15:0] data_addr_nxt = DIRECT_MODE ? {PAGE_PTR, INSTR[6:0]} : sel_aux; // [RULE9] [RULE22]
wire ram_map_select = STATUS_WORD_ONE[`DCD_ST1_CNF_BIT];
reg cond_nxt;
always @*
begin
  case (COND_SEL) // [RULE21]
    2'h1: cond_nxt = CARRY;
    2'h2: cond_nxt = ~CARRY;
    2'h3: cond_nxt = (accum_reg == `DCD_ACC_RST);
    default: cond_nxt = 1'b1;
  endcase
end

////////////////////////////////////////////////////////////////////////
// Interrupts
wire [6:0] int_rise = int_sync2_r & ~int_prev_r;
wire [6:0] int_ready = INT_FLAG & INT_MASK; // [RULE11]
reg [4:0] int_vec_nxt;
integer k;
always @*
begin
  int_vec_nxt = 5'h00;
  for (k = `DCD_INT_LINES - 1; k >= 0; k = k - 1)
    if (int_ready[k])
      int_vec_nxt = k[4:0] + 5'h01;
end
// No take in the cycle after a take, so a held STEP cannot retrigger at once
wire take_ok = STEP && !BUS_WAIT && !INT_TAKE;
wire hw_take = take_ok && !TRAP_SW && int_vec_nxt != 5'h00;
// Serviced line leaves the pending set; a new edge still wins
wire [6:0] int_ack = hw_take ? (7'h01 << (int_vec_nxt - 5'h01)) : 7'h00;
wire [6:0] int_flag_nxt = (INT_FLAG & ~FLAG_CLR & ~int_ack) | int_rise; // [RULE12]

////////////////////////////////////////////////////////////////////////
// Program address sequencing
reg [15:0] nfa_nxt;
always @*
begin
  case (PC_MODE)
    `DCD_PC_JMP: nfa_nxt = PC_TARGET;
    `DCD_PC_CALL: nfa_nxt = PC_TARGET;
    `DCD_PC_RET: nfa_nxt = stack_r[sp_r - 3'h1];
    default: nfa_nxt = next_fetch_addr + 16'h0001; // [RULE20]
  endcase
end

////////////////////////////////////////////////////////////////////////
// Per-entry storage
genvar g;
generate
  for (g = 0; g < 8; g = g + 1)
  begin : g_aux
    always @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        aux_r[g] <= `DCD_WORD_RST;
      else if (AR_LOAD && AR_LOAD_SEL == g)
        aux_r[g] <= AR_LOAD_VAL;
      else if (STEP && AR_UPDATE != `DCD_AR_NONE && AUX_SEL == g)
        aux_r[g] <= aux_addr_arith; // [RULE2]
    end
  end
  for (g = 0; g < `DCD_STACK_DEPTH; g = g + 1)
  begin : g_stack
    always @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        stack_r[g] <= `DCD_WORD_RST;
      else if (STEP && !BUS_WAIT && (PC_MODE == `DCD_PC_CALL || INT_TAKE) && sp_r == g)
        stack_r[g] <= next_fetch_addr; // [RULE24]
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// Main registers
always @(posedge CLK or negedge RST_N)
begin
  if (!RST_N)
  begin
    accum_reg <= `DCD_ACC_RST;
    prod_reg <= `DCD_ACC_RST;
    sp_r <= 3'h0;
    next_fetch_addr <= `DCD_WORD_RST;
    current_fetch_addr <= `DCD_WORD_RST;
    micro_return_store <= `DCD_WORD_RST;
    in_xfer_r <= 1'b0;
    int_sync1_r <= `DCD_INT_RST;
    int_sync2_r <= `DCD_INT_RST;
    int_prev_r <= `DCD_INT_RST;
    pipe_r[0] <= `DCD_WORD_RST;
    pipe_r[1] <= `DCD_WORD_RST;
    pipe_r[2] <= `DCD_WORD_RST;
    pipe_r[3] <= `DCD_WORD_RST;
    PROGRAM_ADDR_BUS <= `DCD_WORD_RST;
    DATA_ADDR <= `DCD_WORD_RST;
    DATA_IN_BLOCK_ZERO <= 1'b0;
    DATA_IN_BLOCK_ONE <= 1'b0;
    DATA_IN_BLOCK_TWO <= 1'b0;
    PROG_IN_BLOCK_ZERO <= 1'b0;
    WRITE_DATA_BUS <= `DCD_WORD_RST;
    ACCUM <= `DCD_ACC_RST;
    CARRY <= 1'b0;
    STATUS_WORD_ONE <= `DCD_ST1_RST;
    PAGE_PTR <= `DCD_PAGE_RST;
    AUX_SEL <= 3'h0;
    AUX_MATCH <= 1'b0;
    COND_TRUE <= 1'b0;
    INT_MASK <= `DCD_INT_RST;
    INT_FLAG <= `DCD_INT_RST;
    INT_TAKE <= 1'b0;
    TRAP_VECTOR <= 5'h00;
    GLOBAL_SPACE_SIZE <= `DCD_WORD_RST;
    PIPE_VALID <= 4'h0;
  end
  else
  begin
    int_sync1_r <= INT_REQ;
    int_sync2_r <= int_sync1_r;
    int_prev_r <= int_sync2_r;
    INT_FLAG <= int_flag_nxt; // [RULE12]
    if (MASK_LOAD)
      INT_MASK <= MASK_VAL; // [RULE11]
    GLOBAL_SPACE_SIZE <= `DCD_WORD_RST; // [RULE10]
    INT_TAKE <= 1'b0;
    if (take_ok && TRAP_SW)
    begin
      INT_TAKE <= 1'b1;
      TRAP_VECTOR <= TRAP_NUM; // [RULE13]
    end
    else if (hw_take)
    begin
      INT_TAKE <= 1'b1;
      TRAP_VECTOR <= int_vec_nxt; // [RULE13]
    end
    if (MUL_LOAD)
      prod_reg <= multiplier; // [RULE15]
    if (STEP)
    begin
      if (ACC_LOAD)
      begin
        accum_reg <= acc_nxt[31:0]; // [RULE5]
        CARRY <= acc_nxt[32];
        ACCUM <= acc_nxt[31:0];
      end
      WRITE_DATA_BUS <= OUT_HIGH ? output_shifter[31:16] : output_shifter[15:0]; // [RULE17]
      DATA_ADDR <= data_addr_nxt;
      DATA_IN_BLOCK_ZERO <= !ram_map_select && data_addr_nxt >= `DCD_B0_DATA_BASE
        && data_addr_nxt <= `DCD_B0_DATA_TOP; // [RULE6] [RULE8]
      DATA_IN_BLOCK_ONE <= data_addr_nxt >= `DCD_B1_BASE && data_addr_nxt <= `DCD_B1_TOP; // [RULE7]
      DATA_IN_BLOCK_TWO <= data_addr_nxt >= `DCD_B2_BASE && data_addr_nxt <= `DCD_B2_TOP; // [RULE7]
      AUX_MATCH <= sel_aux == aux_reg_zero; // [RULE3]
      COND_TRUE <= cond_nxt; // [RULE21]
      if (PTR_LOAD)
        AUX_SEL <= PTR_VAL; // [RULE22]
      if (LOAD_STATUS)
      begin
        STATUS_WORD_ONE <= STATUS_VAL;
        CARRY <= STATUS_VAL[`DCD_ST1_C_BIT];
        PAGE_PTR <= STATUS_VAL[8:0]; // [RULE9]
      end
      else
      begin
        STATUS_WORD_ONE[`DCD_ST1_C_BIT] <= ACC_LOAD ? acc_nxt[32] : CARRY; // [RULE4]
        if (LOAD_PAGE)
          PAGE_PTR <= INSTR[8:0]; // [RULE9]
      end
    end
    if (STEP && !BUS_WAIT)
    begin
      pipe_r[0] <= INSTR; // [RULE25]
      pipe_r[1] <= pipe_r[0];
      pipe_r[2] <= pipe_r[1];
      pipe_r[3] <= pipe_r[2];
      PIPE_VALID <= {PIPE_VALID[2:0], 1'b1};
      if (BLOCK_XFER && !in_xfer_r)
        micro_return_store <= nfa_nxt; // [RULE16]
      in_xfer_r <= BLOCK_XFER;
      if (PC_MODE == `DCD_PC_CALL || INT_TAKE)
        sp_r <= sp_r + 3'h1; // [RULE24]
      else if (PC_MODE == `DCD_PC_RET)
        sp_r <= sp_r - 3'h1;
      if (INT_TAKE)
        next_fetch_addr <= {10'h000, TRAP_VECTOR, 1'b0};
      else if (in_xfer_r && !BLOCK_XFER)
        next_fetch_addr <= micro_return_store; // [RULE16]
      else
        next_fetch_addr <= nfa_nxt; // [RULE18] [RULE20]
      current_fetch_addr <= next_fetch_addr; // [RULE18]
      PROGRAM_ADDR_BUS <= next_fetch_addr;
      PROG_IN_BLOCK_ZERO <= ram_map_select && next_fetch_addr >= `DCD_B0_PROG_BASE; // [RULE6]
    end
    else
      PROGRAM_ADDR_BUS <= current_fetch_addr; // [RULE19]
  end
end

endmodule // dcd_core_datapath

// >>> dcd_mem_model.sv
// Program memory model that inserts wait states
`timescale 1ns/1ps
module dcd_mem_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bus side
  input wire slow,
  input wire [15:0] prog_addr,
  output reg wait_o
);
  reg [15:0] last_r;
  // Slow part stalls once on a new fetch address seen while wait_o is low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_r <= 16'h0000;
      wait_o <= 1'b0;
    end
    else
    begin
      last_r <= prog_addr;
      wait_o <= slow && !wait_o && (prog_addr != last_r);
    end
  end
endmodule // dcd_mem_model

// >>> dcd_core_datapath_checker.sv
// Port assertions for the core datapath
`timescale 1ns/1ps
`include "dcd_defines.vh"
module dcd_core_datapath_checker (
  // Clock and controls
  input wire CLK,
  input wire RST_N,
  input wire STEP,
  input wire [15:0] INSTR,
  input wire DIRECT_MODE,
  input wire LOAD_PAGE,
  input wire LOAD_STATUS,
  input wire [1:0] PC_MODE,
  input wire [15:0] PC_TARGET,
  input wire BUS_WAIT,
  // Outputs watched
  input wire [6:0] INT_FLAG,
  input wire INT_TAKE,
  input wire [15:0] PROGRAM_ADDR_BUS,
  input wire [15:0] DATA_ADDR,
  input wire DATA_IN_BLOCK_ONE,
  input wire DATA_IN_BLOCK_TWO,
  input wire CARRY,
  input wire [15:0] STATUS_WORD_ONE,
  input wire [8:0] PAGE_PTR,
  input wire [15:0] GLOBAL_SPACE_SIZE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Pending interrupts may redirect fetch, so leave them out
  wire pc_go = STEP && !BUS_WAIT && !INT_TAKE && INT_FLAG == 7'h00;
  a_gss_zero: assert property (GLOBAL_SPACE_SIZE == 16'h0000)
    else $error("reserved size nonzero");
  a_wait_hold: assert property (BUS_WAIT |=> $stable(PROGRAM_ADDR_BUS))
    else $error("fetch address moved in wait");
  a_seq_fetch: assert property (pc_go && PC_MODE == 2'h0 ##1 pc_go |=> PROGRAM_ADDR_BUS == $past(PROGRAM_ADDR_BUS) + 16'h0001)
    else $error("no increment");
  a_jump_fetch: assert property (pc_go && PC_MODE == 2'h1 ##1 pc_go |=> PROGRAM_ADDR_BUS == $past(PC_TARGET, 2))
    else $error("jump target lost");
  a_page_hold: assert property (!LOAD_PAGE && !LOAD_STATUS |=> $stable(PAGE_PTR))
    else $error("page changed");
  a_page_load: assert property (STEP && LOAD_PAGE && !LOAD_STATUS |=> PAGE_PTR == $past(INSTR[8:0]))
    else $error("page not loaded");
  a_direct_addr: assert property (STEP && DIRECT_MODE && !LOAD_PAGE && !LOAD_STATUS
    |=> DATA_ADDR == {$past(PAGE_PTR), $past(INSTR[6:0])})
    else $error("direct address wrong");
  a_blk_one: assert property (DATA_IN_BLOCK_ONE == (DATA_ADDR[15:8] == 8'h03))
    else $error("block one hit wrong");
  a_blk_two: assert property (DATA_IN_BLOCK_TWO == (DATA_ADDR[15:5] == 11'h003))
    else $error("block two hit wrong");
  a_carry_status: assert property (CARRY == STATUS_WORD_ONE[`DCD_ST1_C_BIT])
    else $error("carry not in status");
  a_take_pulse: assert property (INT_TAKE |=> !INT_TAKE)
    else $error("take pulse too long");
endmodule // dcd_core_datapath_checker

bind dcd_core_datapath dcd_core_datapath_checker chk_u (.*);

// >>> dcd_core_datapath_tb.sv
// Self-checking bench for the core datapath
`timescale 1ns/1ps
module dcd_core_datapath_tb;
  reg CLK = 0, RST_N = 0, STEP = 0, IN_SEL_PROD = 0, ACC_LOAD = 0, MUL_SIGNED = 0, MUL_LOAD = 0;
  reg OUT_HIGH = 0, DIRECT_MODE = 0, AR_LOAD = 0, PTR_LOAD = 0, LOAD_PAGE = 0, LOAD_STATUS = 0;
  reg BLOCK_XFER = 0, MASK_LOAD = 0, TRAP_SW = 0, slow = 0;
  reg [15:0] INSTR = 0, DATA_IN = 0, MUL_OPND = 0, AR_LOAD_VAL = 0, STATUS_VAL = 0, PC_TARGET = 0;
  reg [6:0] INT_REQ = 0, MASK_VAL = 0, FLAG_CLR = 0;
  reg [4:0] IN_SHIFT = 0, TRAP_NUM = 0;
  reg [2:0] ALU_OP = 0, OUT_SHIFT = 0, AR_LOAD_SEL = 0, PTR_VAL = 0;
  reg [1:0] ACC_SHIFT = 0, PROD_MODE = 0, AR_UPDATE = 0, COND_SEL = 0, PC_MODE = 0;
  wire BUS_WAIT, DATA_IN_BLOCK_ZERO, DATA_IN_BLOCK_ONE, DATA_IN_BLOCK_TWO, PROG_IN_BLOCK_ZERO;
  wire CARRY, AUX_MATCH, COND_TRUE, INT_TAKE;
  wire [31:0] ACCUM;
  wire [15:0] PROGRAM_ADDR_BUS, DATA_ADDR, WRITE_DATA_BUS, STATUS_WORD_ONE, GLOBAL_SPACE_SIZE;
  wire [8:0] PAGE_PTR;
  wire [6:0] INT_MASK, INT_FLAG;
  wire [4:0] TRAP_VECTOR;
  wire [3:0] PIPE_VALID;
  wire [2:0] AUX_SEL;
  integer error_cnt = 0, num_checks = 0, cyc = 0, i, n;
  // Row: operation, shift, data, expected accumulator
  reg [55:0] rows [0:5];
  dcd_core_datapath dut_u (.*);
  dcd_mem_model mem_u (.clk(CLK), .rst_n(RST_N), .slow(slow), .prog_addr(PROGRAM_ADDR_BUS), .wait_o(BUS_WAIT));
  ////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One machine cycle; one-shot controls drop afterwards
  task step;
    STEP = 1;
    @(negedge CLK);
    {STEP, ACC_LOAD, LOAD_PAGE, LOAD_STATUS, AR_LOAD, PTR_LOAD, MASK_LOAD, DIRECT_MODE} = 0;
    {PC_MODE, AR_UPDATE} = 0;
  endtask
  task mul(input [15:0] a, input [15:0] b, input s, input [1:0] m, input [31:0] e);
    {MUL_OPND, DATA_IN, MUL_SIGNED, MUL_LOAD} = {a, b, s, 1'b1};
    @(negedge CLK);
    {MUL_LOAD, PROD_MODE, IN_SEL_PROD, ALU_OP, ACC_LOAD} = {1'b0, m, 1'b1, 3'h0, 1'b1};
    step;
    IN_SEL_PROD = 0;
    chk(ACCUM, e, "product");
  endtask
  task page(input [8:0] p);
    {INSTR, LOAD_PAGE} = {7'h00, p, 1'b1};
    step;
    chk(PAGE_PTR, p, "page");
  endtask
  task daddr(input [6:0] low, input [15:0] e, input [2:0] f);
    {INSTR, DIRECT_MODE} = {9'h000, low, 1'b1};
    step;
    chk(DATA_ADDR, e, "address");
    chk({DATA_IN_BLOCK_ZERO, DATA_IN_BLOCK_ONE, DATA_IN_BLOCK_TWO}, f, "hits");
  endtask
  task stop_test;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
    forever #12.5 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t timeout", $time);
      stop_test;
    end
  end
  initial
  begin
    rows[0] = {3'h0, 5'h00, 16'h0005, 32'h00000005};
    rows[1] = {3'h1, 5'h04, 16'h0003, 32'h00000035};
    rows[2] = {3'h2, 5'h10, 16'h0001, 32'hffff0035};
    rows[3] = {3'h4, 5'h10, 16'h7fff, 32'h7fff0000};
    rows[4] = {3'h5, 5'h00, 16'h00ff, 32'h7fff00ff};
    rows[5] = {3'h6, 5'h08, 16'h0fff, 32'h7ff0ffff};
    repeat (16) @(negedge CLK);
    RST_N = 1;
    @(negedge CLK);
    chk(ACCUM, 32'h0, "acc reset");
    for (i = 0; i < 6; i = i + 1)
    begin
      {ALU_OP, IN_SHIFT, DATA_IN} = rows[i][55:32];
      ACC_LOAD = 1;
      step;
      chk(ACCUM, rows[i][31:0], "alu");
    end
    mul(16'hfffe, 16'h0003, 1'b1, 2'h0, 32'hfffffffa);
    mul(16'hfffe, 16'h0003, 1'b1, 2'h3, 32'hffffffff);
    mul(16'h0123, 16'h0010, 1'b0, 2'h2, 32'h00012300);
    mul(16'hfffe, 16'h0003, 1'b0, 2'h1, 32'h0005fff4);
    {OUT_SHIFT, OUT_HIGH} = {3'h7, 1'b1};
    repeat (2) step;
    chk(WRITE_DATA_BUS, 16'h02ff, "high half");
    OUT_HIGH = 0;
    repeat (2) step;
    chk(WRITE_DATA_BUS, 16'hfa00, "low half");
    {ACC_SHIFT, ACC_LOAD, COND_SEL} = {2'h3, 1'b1, 2'h2};
    step;
    ACC_SHIFT = 0;
    chk(ACCUM, 32'h0002fffa, "rotate");
    chk({CARRY, COND_TRUE, GLOBAL_SPACE_SIZE}, 18'h10000, "carry cond");
    page(9'h006);
    daddr(7'h7f, 16'h037f, 3'b010);
    page(9'h000);
    daddr(7'h60, 16'h0060, 3'b001);
    page(9'h004);
    daddr(7'h00, 16'h0200, 3'b100);
    {STATUS_VAL, LOAD_STATUS} = {16'h1004, 1'b1};
    step;
    daddr(7'h00, 16'h0200, 3'b000);
    {PC_TARGET, PC_MODE} = {16'hff10, 2'h1};
    repeat (2) step;
    chk({PROG_IN_BLOCK_ZERO, PROGRAM_ADDR_BUS}, 17'h1ff10, "program map");
    {AR_LOAD, AR_LOAD_SEL, AR_LOAD_VAL, PTR_LOAD, PTR_VAL} = {1'b1, 3'h1, 16'hffff, 1'b1, 3'h1};
    step;
    chk(AUX_SEL, 3'h1, "select");
    AR_UPDATE = 2'h1;
    repeat (2) step;
    chk(DATA_ADDR, 16'h0000, "wrap");
    chk(AUX_MATCH, 1'b1, "match");
    // Wait states from the slow memory
    slow = 1;
    repeat (12) step;
    slow = 0;
    INT_REQ = 7'h01;
    n = 0;
    repeat (5)
    begin
      @(negedge CLK);
      n = n + INT_TAKE;
    end
    chk({(n != 0), INT_FLAG}, 8'h01, "masked line");
    {FLAG_CLR, MASK_VAL, MASK_LOAD} = {7'h01, 7'h04, 1'b1};
    step;
    FLAG_CLR = 0;
    chk({INT_FLAG, INT_MASK}, 14'h0004, "mask");
    INT_REQ = 7'h05;
    STEP = 1;
    n = 0;
    while (INT_TAKE !== 1'b1 && n < 12)
    begin
      @(negedge CLK);
      n = n + 1;
    end
    chk({INT_TAKE, TRAP_VECTOR}, 6'h23, "vector");
    @(negedge CLK);
    chk({INT_TAKE, INT_FLAG}, 8'h00, "serviced");
    STEP = 0;
    chk(PIPE_VALID, 4'hf, "pipe");
    stop_test;
  end
endmodule // dcd_core_datapath_tb
